// File: design/supply_ctrl_map.vh
`ifndef SUPPLY_CTRL_MAP_VH
`define SUPPLY_CTRL_MAP_VH
// ==========================================
// register byte offsets
`define OFF_INTEN_CLR 8'h00
`define OFF_INTEN_SET 8'h04
`define OFF_INTERRUPT_FLAG_REG 8'h08
`define OFF_STATUS 8'h0C
`define OFF_MON0 8'h34
`define OFF_MON_STEP 8'h04
`define OFF_REGU 8'h3C
`define OFF_REFS 8'h40
// ==========================================
// supply monitor register fields
`define MON_EN 1
`define MON_HYSTERESIS_ENABLE 2
`define MON_ACT 3
`define MON_MODE 8
`define MON_CEN 9
`define MON_PSEL_LO 12
`define MON_PSEL_HI 15
`define MON_LVL_LO 16
`define MON_LVL_HI 21
`define MON_CFG_MASK 32'h003F_F30E
`define MON_NVM_MASK 32'h003F_F00E
`define CORE_MON_RST 32'h0007_0002
// ==========================================
// regulator and reference fields
`define REG_EN 1
`define REG_WATCH 2
`define REG_LVL_LO 16
`define REG_LVL_HI 20
`define REGU_MASK 32'h001F_0006
`define REF_TEMP_SENSOR_ENABLE 1
`define REF_BGOUT 2
`define REF_TRIM_LO 16
`define REF_TRIM_HI 26
`define REFS_MASK 32'h07FF_0006
// ==========================================
// interrupt flag layout
`define NFLAG 18
`define FLAG_MASK 32'h0003_FFFF
`define FLAG_LOCK_LOST 16
// ==========================================
// timing
`define CLK_HZ 100000000
`define PRESC_HZ 1000
`define SYNC_CYC 3'h4
`define SAMPLE_CYC 4'h8
`define LT_UNIT_CYC 16'h03E8
// ==========================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: design/supply_monitor_control_irq.v
// Summary of operation
// - enabled analog monitor trips reset or interrupt
// - analog detect result readable in status
// - analog config loaded from user nvm
// - mode zero monitors continuously
// - no continuous core monitoring in standby
// - both monitors reset to continuous mode
// - mode one samples briefly once per sample period
// - sample period is 2^(psel+1) ticks of 1kHz
// - monitor writes dropped while sync busy
// - write clears sync ready until done
// - hysteresis bit adds threshold hysteresis
// - regulator enabled after reset, software off
// - regulator level loaded from factory trim
// - core watch forces power-on reset
// - reference trim loaded, software overridable
// - temp sensor and bandgap route enables
// - rising status edges set flags
// - pll lock, lock lost, timeout flags
// - enable set and clear registers
// - request while flag and enable
// - all requests ored to one line
// - writing one clears a flag
`timescale 1ns/1ns
`include "supply_ctrl_map.vh"
module supply_monitor_control_irq #(
  parameter TICK_DIV = `CLK_HZ / `PRESC_HZ
)
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // calibration loaded at reset
  input wire [31:0] nvm_analog_cfg,
  input wire [4:0] factory_regulator_level,
  input wire [10:0] factory_reference_trim,
  // asynchronous status pins
  input wire [8:0] osc_status,
  input wire analog_monitor_ready,
  input wire analog_below_threshold,
  input wire core_monitor_ready,
  input wire core_below_threshold,
  input wire pll_lock,
  input wire core_supply_critical,
  input wire standby_sleep,
  input wire pll_enable,
  // same-clock pll setting
  input wire [2:0] pll_lock_time_setting,
  // supply monitor controls
  output wire analog_monitor_active,
  output wire analog_hysteresis_enable,
  output wire [5:0] analog_monitor_level,
  output wire analog_reset_request,
  output wire core_monitor_active,
  output wire core_hysteresis_enable,
  output wire [5:0] core_monitor_level,
  output wire core_reset_request,
  // regulator and reference controls
  output reg core_regulator_enable,
  output reg [4:0] core_regulator_level,
  output reg por_request,
  output reg temp_sensor_enable,
  output reg bandgap_output_enable,
  output reg [10:0] reference_trim,
  // combined interrupt
  output reg system_control_irq
);

  // ==========================================
  // input synchronisers
  localparam NSYNC = 17;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] sync_a;
  reg [NSYNC-1:0] sync_b;
  assign async_in = {pll_enable, standby_sleep, core_supply_critical,
    pll_lock, core_below_threshold, core_monitor_ready,
    analog_below_threshold, analog_monitor_ready, osc_status};

  // two flops per pin, first stage read only by the second
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_a <= {NSYNC{1'b0}};
      sync_b <= {NSYNC{1'b0}};
    end
    else
    begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  wire s_standby = sync_b[15];
  wire s_lock = sync_b[13];
  wire s_pll_en = sync_b[16];

  // ==========================================
  // axi4-lite slave
  reg aw_full;
  reg w_full;
  reg [7:0] waddr;
  reg [31:0] wdat;
  reg [3:0] wstr;
  wire wr_fire = aw_full & w_full & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{wstr[3]}}, {8{wstr[2]}},
    {8{wstr[1]}}, {8{wstr[0]}}};
  wire [31:0] wbits = wdat & wmask;
  reg wr_mapped;
  reg [31:0] rd_data;
  reg rd_mapped;

  // address and data taken in either order, response after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      waddr <= 8'h00;
      wdat <= 32'h0000_0000;
      wstr <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        waddr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdat <= s_axi_wdata;
        wstr <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // one read at a time, answered the cycle after the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // 1khz prescaler tick from the system clock
  localparam [16:0] TICK_LAST = TICK_DIV[16:0] - 17'h0_0001;
  reg [16:0] tick_cnt;
  reg tick;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt <= 17'h0_0000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 17'h0_0000 : tick_cnt + 17'h0_0001;
    end
  end

  // ==========================================
  // supply monitors: 0 analog rail, 1 core rail
  wire [63:0] mon_cfg;
  wire [1:0] mon_srdy;
  wire [1:0] mon_det;
  wire [1:0] mon_act;
  wire [1:0] mon_rst;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : mon
      localparam [7:0] OFF = (i == 0) ? `OFF_MON0 :
        `OFF_MON0 + `OFF_MON_STEP;
      reg [31:0] cfg;
      reg srdy;
      reg [2:0] scnt;
      reg [16:0] scnt_t;
      reg [3:0] win;
      reg det;
      reg active;
      reg rst_req;
      wire en = cfg[`MON_EN];
      wire smode = cfg[`MON_MODE];
      wire [3:0] psel = cfg[`MON_PSEL_HI:`MON_PSEL_LO];
      wire below = sync_b[10 + 2 * i];
      wire blocked = (i == 1) & s_standby;
      wire [16:0] last = (17'h0_0001 << ({1'b0, psel} + 5'h01)) - 17'h0_0001;
      wire start = tick & cfg[`MON_CEN] & smode & (scnt_t >= last);
      wire accept = wr_fire & (waddr == OFF) & srdy;

      // config load, guarded writes and write synchronisation
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          if (i == 0)
            cfg <= nvm_analog_cfg & `MON_NVM_MASK;
          else
            cfg <= `CORE_MON_RST;
          srdy <= 1'b1;
          scnt <= 3'h0;
        end
        else if (accept)
        begin
          cfg <= ((cfg & ~wmask) | wbits) & `MON_CFG_MASK;
          srdy <= 1'b0;
          scnt <= `SYNC_CYC;
        end
        else if (!srdy)
        begin
          scnt <= scnt - 3'h1;
          srdy <= (scnt == 3'h1);
        end
      end

      // sampling period counter and measurement window
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          scnt_t <= 17'h0_0000;
          win <= 4'h0;
        end
        else
        begin
          if (!(cfg[`MON_CEN] && smode))
            scnt_t <= 17'h0_0000;
          else if (start)
            scnt_t <= 17'h0_0000;
          else if (tick)
            scnt_t <= scnt_t + 17'h0_0001;
          if (start && en)
            win <= `SAMPLE_CYC;
          else if (win != 4'h0)
            win <= win - 4'h1;
        end
      end

      // comparator enable, detection result and reset action
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          active <= 1'b0;
          det <= 1'b0;
          rst_req <= 1'b0;
        end
        else
        begin
          if (!en)
            active <= 1'b0;
          else if (smode)
            active <= (start | (win > 4'h1));
          else
            active <= ~blocked;
          if (!en)
            det <= 1'b0;
          else if (!smode)
            det <= below & ~blocked;
          else if (win == 4'h1)
            det <= below;
          rst_req <= en & det & ~cfg[`MON_ACT];
        end
      end

      assign mon_cfg[32 * i + 31:32 * i] = cfg;
      assign mon_srdy[i] = srdy;
      assign mon_det[i] = det;
      assign mon_act[i] = active;
      assign mon_rst[i] = rst_req;
    end
  endgenerate

  assign analog_monitor_active = mon_act[0];
  assign analog_hysteresis_enable = mon_cfg[`MON_HYSTERESIS_ENABLE];
  assign analog_monitor_level = mon_cfg[`MON_LVL_HI:`MON_LVL_LO];
  assign analog_reset_request = mon_rst[0];
  assign core_monitor_active = mon_act[1];
  assign core_hysteresis_enable = mon_cfg[32 + `MON_HYSTERESIS_ENABLE];
  assign core_monitor_level = mon_cfg[32 + `MON_LVL_HI:32 + `MON_LVL_LO];
  assign core_reset_request = mon_rst[1];

  // ==========================================
  // regulator and reference controls
  reg [31:0] regu;
  reg [31:0] refs;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      regu <= {11'h000, factory_regulator_level, 16'h0002};
      refs <= {5'h00, factory_reference_trim, 16'h0000};
    end
    else if (wr_fire)
    begin
      if (waddr == `OFF_REGU)
        regu <= ((regu & ~wmask) | wbits) & `REGU_MASK;
      if (waddr == `OFF_REFS)
        refs <= ((refs & ~wmask) | wbits) & `REFS_MASK;
    end
  end

  // control outputs registered from the settings
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_regulator_enable <= 1'b1;
      core_regulator_level <= 5'h00;
      por_request <= 1'b0;
      temp_sensor_enable <= 1'b0;
      bandgap_output_enable <= 1'b0;
      reference_trim <= 11'h000;
    end
    else
    begin
      core_regulator_enable <= regu[`REG_EN];
      core_regulator_level <= regu[`REG_LVL_HI:`REG_LVL_LO];
      por_request <= regu[`REG_WATCH] & sync_b[14];
      temp_sensor_enable <= refs[`REF_TEMP_SENSOR_ENABLE];
      bandgap_output_enable <= refs[`REF_BGOUT];
      reference_trim <= refs[`REF_TRIM_HI:`REF_TRIM_LO];
    end
  end

  // ==========================================
  // pll lock timer
  reg pll_en_q;
  reg lt_run;
  reg lt_done;
  reg [15:0] lt_cnt;

  // counts the programmed lock time from pll start
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_en_q <= 1'b0;
      lt_run <= 1'b0;
      lt_done <= 1'b0;
      lt_cnt <= 16'h0000;
    end
    else
    begin
      pll_en_q <= s_pll_en;
      if (!s_pll_en)
      begin
        lt_run <= 1'b0;
        lt_done <= 1'b0;
      end
      else if (!pll_en_q)
      begin
        lt_cnt <= {13'h0000, pll_lock_time_setting} * `LT_UNIT_CYC;
        lt_run <= (pll_lock_time_setting != 3'h0);
      end
      else if (lt_run)
      begin
        lt_cnt <= lt_cnt - 16'h0001;
        if (lt_cnt == 16'h0001)
        begin
          lt_run <= 1'b0;
          lt_done <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // status, edge flags and combined request
  wire [`NFLAG-1:0] stat;
  reg [`NFLAG-1:0] stat_q;
  reg [`NFLAG-1:0] flag;
  reg [`NFLAG-1:0] inten;
  reg [`NFLAG-1:0] fset;
  wire [`NFLAG-1:0] fclr;
  wire [`NFLAG-1:0] eset;
  wire [`NFLAG-1:0] eclr;
  assign stat = {lt_done, 1'b0, s_lock, mon_srdy[1], mon_det[1],
    sync_b[11], mon_srdy[0], mon_det[0], sync_b[9], sync_b[8:0]};
  assign fclr = (wr_fire && waddr == `OFF_INTERRUPT_FLAG_REG) ?
    wbits[`NFLAG-1:0] : {`NFLAG{1'b0}};
  assign eset = (wr_fire && waddr == `OFF_INTEN_SET) ?
    wbits[`NFLAG-1:0] : {`NFLAG{1'b0}};
  assign eclr = (wr_fire && waddr == `OFF_INTEN_CLR) ?
    wbits[`NFLAG-1:0] : {`NFLAG{1'b0}};

  // rising edges of status, plus falling lock while pll runs
  always @*
  begin
    fset = stat & ~stat_q;
    fset[`FLAG_LOCK_LOST] = ~s_lock & stat_q[15] & s_pll_en;
  end

  // flags, enables and request line
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= {`NFLAG{1'b1}};
      flag <= {`NFLAG{1'b0}};
      inten <= {`NFLAG{1'b0}};
      system_control_irq <= 1'b0;
    end
    else
    begin
      stat_q <= stat;
      flag <= (flag & ~fclr) | fset;
      inten <= (inten | eset) & ~eclr;
      system_control_irq <= |(flag & inten);
    end
  end

  // ==========================================
  // register decode for writes and reads
  always @*
  begin
    wr_mapped = 1'b1;
    case (waddr)
      `OFF_INTEN_CLR, `OFF_INTEN_SET, `OFF_INTERRUPT_FLAG_REG, `OFF_STATUS,
      `OFF_MON0, `OFF_MON0 + `OFF_MON_STEP, `OFF_REGU, `OFF_REFS:
        wr_mapped = 1'b1;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  always @*
  begin
    rd_mapped = 1'b1;
    rd_data = 32'h0000_0000;
    case (s_axi_araddr)
      `OFF_INTEN_CLR, `OFF_INTEN_SET:
        rd_data = {14'h0000, inten};
      `OFF_INTERRUPT_FLAG_REG:
        rd_data = {14'h0000, flag};
      `OFF_STATUS:
        rd_data = {14'h0000, stat};
      `OFF_MON0:
        rd_data = mon_cfg[31:0];
      `OFF_MON0 + `OFF_MON_STEP:
        rd_data = mon_cfg[63:32];
      `OFF_REGU:
        rd_data = regu;
      `OFF_REFS:
        rd_data = refs;
      default:
        rd_mapped = 1'b0;
    endcase
  end

endmodule

// File: test/supply_ctrl_properties.sv
`timescale 1ns/1ns
// ==========================================
// port checker
module supply_ctrl_properties #(
  parameter TICK_DIV = 10
)
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // controls
  input wire core_supply_critical,
  input wire por_request,
  input wire core_regulator_enable,
  input wire analog_hysteresis_enable,
  input wire [5:0] analog_monitor_level,
  input wire [10:0] reference_trim,
  input wire system_control_irq
);
  reg [2:0] since_wr;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the last accepted write data
  always @(posedge aclk)
  begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready))
      since_wr <= 3'h0;
    else if (since_wr != 3'h7)
      since_wr <= since_wr + 3'h1;
  end
  // answers hold until taken
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  AST_R_CAUSE: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  AST_AW_REOPEN: assert property (
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");
  // state right after reset
  AST_RST_STATE: assert property (
    $rose(aresetn) |-> core_regulator_enable && !system_control_irq)
    else $error("wrong state after reset");
  // only writes drop the request or move the controls; reset request only after critical supply
  AST_IRQ_FALL: assert property (
    $fell(system_control_irq) |-> since_wr < 3'h5)
    else $error("request dropped without a write");
  AST_CFG_WRITE: assert property (
    !$stable({analog_hysteresis_enable, analog_monitor_level,
      reference_trim, core_regulator_enable}) |-> since_wr < 3'h5)
    else $error("control moved without a write");
  AST_POR_CAUSE: assert property (
    por_request |-> $past(core_supply_critical, 2) ||
      $past(core_supply_critical, 3) || $past(core_supply_critical, 4))
    else $error("reset request without critical supply");
  // main scenarios
  COV_IRQ: cover property ($rose(system_control_irq));
  COV_POR: cover property ($rose(por_request));
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind supply_monitor_control_irq supply_ctrl_properties #(
  .TICK_DIV(TICK_DIV)
) u_supply_ctrl_properties (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .core_supply_critical, .por_request, .core_regulator_enable,
  .analog_hysteresis_enable, .analog_monitor_level, .reference_trim,
  .system_control_irq
);

// File: test/supply_monitor_control_irq_test.sv
`timescale 1ns/1ns
`include "supply_ctrl_map.vh"
module supply_monitor_control_irq_test;
  localparam TICK = 10;
  localparam NVM = 32'h0015_F306;
  localparam ALL = 32'hFFFF_FFFF;
  // ==========================================
  // design ports
  reg aclk;
  reg aresetn;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg [8:0] osc_status;
  reg analog_monitor_ready, analog_below_threshold, core_monitor_ready;
  reg core_below_threshold, pll_lock, core_supply_critical;
  reg standby_sleep, pll_enable;
  reg [2:0] pll_lock_time_setting;
  wire analog_monitor_active, analog_hysteresis_enable, analog_reset_request;
  wire core_monitor_active, core_reset_request, core_regulator_enable;
  wire [5:0] analog_monitor_level, core_monitor_level;
  wire [4:0] core_regulator_level;
  wire core_hysteresis_enable;
  wire por_request, temp_sensor_enable, bandgap_output_enable;
  wire system_control_irq;
  wire [10:0] reference_trim;
  integer error_cnt, checked, cyc;
  supply_monitor_control_irq #(
    .TICK_DIV(TICK)
  ) u_supply_monitor_control_irq (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .nvm_analog_cfg(NVM), .factory_regulator_level(5'h0b),
    .factory_reference_trim(11'h2a5), .osc_status, .analog_monitor_ready,
    .analog_below_threshold, .core_monitor_ready, .core_below_threshold,
    .pll_lock, .core_supply_critical, .standby_sleep, .pll_enable,
    .pll_lock_time_setting, .analog_monitor_active,
    .analog_hysteresis_enable, .analog_monitor_level, .analog_reset_request,
    .core_monitor_active, .core_hysteresis_enable, .core_monitor_level,
    .core_reset_request, .core_regulator_enable, .core_regulator_level,
    .por_request, .temp_sensor_enable, .bandgap_output_enable,
    .reference_trim, .system_control_irq
  );
  // ==========================================
  // clock and watchdog
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  // ==========================================
  // shared tasks
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // unmapped offsets answer with an error
  function [1:0] resp_of(input [7:0] a);
    resp_of = (a < 8'h10 || (a >= `OFF_MON0 && a <= `OFF_REFS)) ?
      `RESP_OKAY : `RESP_SLVERR;
  endfunction
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
      while ((s_axi_awvalid && !s_axi_awready) ||
        (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid)
        @(posedge aclk);
      check(s_axi_bresp, resp_of(a));
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp, input [31:0] m);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid)
        @(posedge aclk);
      check(s_axi_rdata & m, exp);
      check(s_axi_rresp, resp_of(a));
      s_axi_rready <= 1'b0;
    end
  endtask
  task do_reset;
    begin
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
    end
  endtask
  task reset_vals;
    begin
      rd_chk(`OFF_MON0, NVM & `MON_NVM_MASK, ALL);
      rd_chk(`OFF_MON0 + `OFF_MON_STEP, 32'h0007_0002, ALL);
      rd_chk(`OFF_REGU, 32'h000B_0002, ALL);
      rd_chk(`OFF_REFS, 32'h02A5_0000, ALL);
      check(core_regulator_enable, 1);
      check(core_regulator_level, 5'h0b);
      check({core_hysteresis_enable, core_monitor_level}, 7'h07);
      check(analog_monitor_active, 1);
    end
  endtask
  // one sampled-mode window and period for a prescale value
  task sampled(input [3:0] ps);
    integer n;
    begin
      wr(`OFF_MON0, {16'h0020, ps, 12'h102});
      repeat (8) @(posedge aclk);
      wr(`OFF_MON0, {16'h0020, ps, 12'h302});
      while (analog_monitor_active)
        @(posedge aclk);
      while (!analog_monitor_active)
        @(posedge aclk);
      n = 0;
      while (analog_monitor_active)
      begin
        n = n + 1;
        @(posedge aclk);
      end
      check(n, `SAMPLE_CYC);
      while (!analog_monitor_active)
      begin
        n = n + 1;
        @(posedge aclk);
      end
      check(n, TICK << (ps + 1));
    end
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
      s_axi_bready, s_axi_arvalid, s_axi_rready, osc_status,
      analog_monitor_ready, analog_below_threshold, core_monitor_ready,
      core_below_threshold, pll_lock, core_supply_critical, standby_sleep,
      pll_enable, pll_lock_time_setting, aresetn} = '0;
    s_axi_wstrb = 4'hf;
    do_reset;
    reset_vals;
    // every status register input pin rises together
    {osc_status, analog_monitor_ready, analog_below_threshold,
      core_monitor_ready, core_below_threshold, pll_lock} <= 14'h3fff;
    repeat (6) @(posedge aclk);
    check({analog_reset_request, core_reset_request}, 2'h3);
    rd_chk(`OFF_STATUS, 32'h0000_FFFF, ALL);
    rd_chk(`OFF_INTERRUPT_FLAG_REG, 32'h0000_B7FF, ALL);
    wr(`OFF_INTERRUPT_FLAG_REG, ALL);
    rd_chk(`OFF_INTERRUPT_FLAG_REG, 32'h0000_0000, ALL);
    // lock lost and lock timer
    pll_lock_time_setting <= 3'h1;
    pll_enable <= 1'b1;
    {analog_below_threshold, core_below_threshold, pll_lock} <= 3'h0;
    repeat (`LT_UNIT_CYC + 20) @(posedge aclk);
    rd_chk(`OFF_INTERRUPT_FLAG_REG, 32'h0003_0000, ALL);
    // enables and the combined request
    check(system_control_irq, 0);
    wr(`OFF_INTEN_SET, 32'h0001_0000);
    wr(`OFF_INTEN_CLR, 32'hFFFE_FFFF);
    repeat (3) @(posedge aclk);
    check(system_control_irq, 1);
    wr(`OFF_INTEN_CLR, 32'h0001_0000);
    repeat (3) @(posedge aclk);
    check(system_control_irq, 0);
    wr(`OFF_INTEN_SET, 32'h0003_0000);
    rd_chk(`OFF_INTEN_CLR, 32'h0003_0000, ALL);
    wr(`OFF_INTERRUPT_FLAG_REG, 32'h0001_0000);
    repeat (3) @(posedge aclk);
    check(system_control_irq, 1);
    rd_chk(`OFF_INTERRUPT_FLAG_REG, 32'h0002_0000, ALL);
    wr(`OFF_INTERRUPT_FLAG_REG, 32'h0002_0000);
    repeat (3) @(posedge aclk);
    check(system_control_irq, 0);
    // a second write during synchronization is dropped
    fork
      begin
        wr(`OFF_MON0, 32'h0020_0002);
        wr(`OFF_MON0, 32'h003F_0006);
      end
      begin
        repeat (2) @(posedge aclk);
        rd_chk(`OFF_STATUS, 32'h0000_0000, 32'h0000_0800);
      end
    join
    repeat (8) @(posedge aclk);
    rd_chk(`OFF_MON0, 32'h0020_0002, ALL);
    rd_chk(`OFF_STATUS, 32'h0000_0800, 32'h0000_0800);
    rd_chk(`OFF_INTERRUPT_FLAG_REG, 32'h0000_0800, 32'h0000_0800);
    check({analog_hysteresis_enable, analog_monitor_level}, 7'h20);
    // interrupt action and hysteresis
    wr(`OFF_MON0, 32'h0020_000E);
    repeat (8) @(posedge aclk);
    analog_below_threshold <= 1'b1;
    repeat (6) @(posedge aclk);
    check({analog_hysteresis_enable, analog_reset_request}, 2'h2);
    rd_chk(`OFF_INTERRUPT_FLAG_REG, 32'h0000_0400, 32'h0000_0400);
    analog_below_threshold <= 1'b0;
    sampled(4'h0);
    sampled(4'h1);
    // core monitor is held off in standby
    core_below_threshold <= 1'b1;
    standby_sleep <= 1'b1;
    repeat (6) @(posedge aclk);
    check({core_monitor_active, core_reset_request}, 2'h0);
    standby_sleep <= 1'b0;
    repeat (6) @(posedge aclk);
    check({core_monitor_active, core_reset_request}, 2'h3);
    core_below_threshold <= 1'b0;
    // regulator, core watch and reference
    wr(`OFF_REGU, 32'h000B_0004);
    core_supply_critical <= 1'b1;
    repeat (6) @(posedge aclk);
    check({core_regulator_enable, por_request}, 2'h1);
    core_supply_critical <= 1'b0;
    repeat (6) @(posedge aclk);
    check(por_request, 0);
    wr(`OFF_REFS, 32'h0155_0006);
    repeat (3) @(posedge aclk);
    check({temp_sensor_enable, bandgap_output_enable, reference_trim},
      13'h1955);
    wr(`OFF_REFS, 32'h0155_0002);
    repeat (3) @(posedge aclk);
    check(bandgap_output_enable, 0);
    // unmapped places, read and written
    rd_chk(8'h80, 32'h0000_0000, ALL);
    wr(8'h10, ALL);
    do_reset;
    reset_vals;
    give_verdict;
  end
endmodule
